// >>> hdl/cdsr_consts.svh
/*
 * Constants for the charger detail status register bank: target address,
 * register offsets, field positions, reset values and synchroniser layout.
 * Assumes it is included by bare name from the design and the host model.
 */
`ifndef CDSR_CONSTS_SVH
`define CDSR_CONSTS_SVH

// --------------------------------------------------------------------------
// serial target address and register offsets
// --------------------------------------------------------------------------
`define CDSR_TARGET_ADDR 7'h6A
`define CDSR_OFS_INPUT_THERMAL 8'h03
`define CDSR_OFS_BATTERY_CHARGER 8'h04
`define CDSR_UNMAPPED_DATA 8'h00

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define CDSR_BIT_INPUT_VOLTAGE_INVALID 7
`define CDSR_BIT_INPUT_CURRENT_LIMITED 6
`define CDSR_BIT_INPUT_OVERVOLTAGE 5
`define CDSR_BIT_INPUT_ABOVE_BATTERY 4
`define CDSR_BIT_UNUSED_BIT 3
`define CDSR_THM_MSB 2
`define CDSR_THM_LSB 0
`define CDSR_BAT_MSB 5
`define CDSR_BAT_LSB 4
`define CDSR_CHG_MSB 3
`define CDSR_CHG_LSB 0

// --------------------------------------------------------------------------
// reset values: input valid, normal zone, battery ok, charger off
// --------------------------------------------------------------------------
`define CDSR_RST_INPUT_THERMAL 8'h13
`define CDSR_RST_BATTERY_CHARGER 8'h28

// --------------------------------------------------------------------------
// pin synchroniser layout
// --------------------------------------------------------------------------
`define CDSR_SYNC_W 14
`define CDSR_SYNC_RST 14'h0003
`define CDSR_S_SCL 0
`define CDSR_S_SDA 1
`define CDSR_S_STANDBY 2
`define CDSR_S_PGOOD 3
`define CDSR_S_IN_VALID 4
`define CDSR_S_IN_LIMITED 5
`define CDSR_S_IN_OVP 6
`define CDSR_S_IN_ABOVE_BAT 7
`define CDSR_S_T0 8
`define CDSR_S_T15 9
`define CDSR_S_T45 10
`define CDSR_S_T60 11
`define CDSR_S_BAT_2V1 12
`define CDSR_S_BAT_OV 13

`endif

// >>> hdl/cdsr_pkg.sv
/*
 * Types for the charger detail status register bank: field encodings and
 * the serial target state machine.
 * Assumes the constants header sits beside it.
 */
`default_nettype none
package cdsr_pkg;

    // --------------------------------------------------------------------------
    // field encodings
    // --------------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        CDSR_THM_COLD = 3'h1,
        CDSR_THM_COOL = 3'h2,
        CDSR_THM_NORMAL = 3'h3,
        CDSR_THM_WARM = 3'h4,
        CDSR_THM_HOT = 3'h5
    } cdsr_thm_t;

    typedef enum logic [1:0]
    {
        CDSR_BAT_DEAD = 2'h0,
        CDSR_BAT_TIMER = 2'h1,
        CDSR_BAT_OK = 2'h2,
        CDSR_BAT_OVER = 2'h3
    } cdsr_bat_t;

    typedef enum logic [3:0]
    {
        CDSR_CHG_DEAD = 4'h0,
        CDSR_CHG_PREQUAL = 4'h1,
        CDSR_CHG_FAST_CC = 4'h2,
        CDSR_CHG_FAST_CV = 4'h3,
        CDSR_CHG_TOPOFF = 4'h4,
        CDSR_CHG_DONE = 4'h5,
        CDSR_CHG_TIMER_FAULT = 4'h6,
        CDSR_CHG_TEMP_SUSPEND = 4'h7,
        CDSR_CHG_OFF = 4'h8,
        CDSR_CHG_THERMAL_LOOP = 4'h9
    } cdsr_chg_t;

    // --------------------------------------------------------------------------
    // serial target states, one-hot
    // --------------------------------------------------------------------------
    typedef enum logic [7:0]
    {
        CDSR_ST_IDLE = 8'h01,
        CDSR_ST_ADDR = 8'h02,
        CDSR_ST_ADDR_ACK = 8'h04,
        CDSR_ST_PTR = 8'h08,
        CDSR_ST_PTR_ACK = 8'h10,
        CDSR_ST_WDATA = 8'h20,
        CDSR_ST_TX = 8'h40,
        CDSR_ST_HOST_ACK = 8'h80
    } cdsr_state_t;

endpackage : cdsr_pkg
`default_nettype wire

// >>> hdl/cdsr_status_regs.sv
/*
 * Two read-only detail status registers of a one-cell charger and the
 * serial two-wire target that reads them out.
 * Assumes comparator outputs and the two-wire pins are asynchronous, the
 * charge controller phase inputs come from logic on i_clock, and an external
 * pull-up on the data wire.
 */
//
// Overview of operation
// RULE_01 - input voltage invalid bit is 0 when input valid above 4.5V, else 1
// RULE_02 - input current limited bit follows the input current limiter
// RULE_03 - input overvoltage bit is 1 when input exceeds overvoltage threshold
// RULE_04 - input above battery bit is 1 when input exceeds battery voltage
// RULE_05 - zone reads 010 cool, 011 normal, 100 warm
// RULE_06 - zone reads 001 below 0C and 101 above 60C, charging suspended
// RULE_07 - battery below 2.1V reads condition 00 and charger state 0000
// RULE_08 - timer fault reads condition 01 and charger state 0110
// RULE_09 - battery condition reads 10 when no battery problem exists
// RULE_10 - battery condition reads 11 above battery overvoltage threshold
// RULE_11 - battery overvoltage only reported while input supply is valid
// RULE_12 - charger state 0000 dead battery, 0001 prequalification
// RULE_13 - charger state 0010 constant current, 0011 constant voltage
// RULE_14 - charger state 0100 top-off, 0101 done
// RULE_15 - charger state 0111 while suspended for thermistor zone
// RULE_16 - charger state 1000 when input invalid or charging disabled
// RULE_17 - charger state 1001 when thermal loop active while charging
// RULE_18 - both registers read-only at target 0x6A, offsets 0x03 and 0x04
// RULE_19 - registers reset on standby supply loss or power-good rising edge
// RULE_20 - first register: four input bits, zero bit 3, zone in 2..0
// RULE_21 - second register: condition 5..4, state 3..0, top bits zero
//
`timescale 1ns/1ns
`default_nettype none
`include "cdsr_consts.svh"

module cdsr_status_regs
    import cdsr_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    input wire logic i_standby_supply_valid,
    input wire logic i_safeout_power_good,
    input wire logic i_input_valid,
    input wire logic i_input_limited,
    input wire logic i_input_above_ovp,
    input wire logic i_input_above_battery,
    input wire logic i_temp_above_0c,
    input wire logic i_temp_above_15c,
    input wire logic i_temp_above_45c,
    input wire logic i_temp_above_60c,
    input wire logic i_battery_above_2v1,
    input wire logic i_battery_above_ov_threshold,
    input wire logic i_charger_enable,
    input wire logic i_timer_fault,
    input wire logic i_phase_prequal,
    input wire logic i_phase_fast_cc,
    input wire logic i_phase_fast_cv,
    input wire logic i_phase_topoff,
    input wire logic i_phase_done,
    input wire logic i_thermal_loop_active,
    output logic [7:0] o_input_thermal_status,
    output logic [7:0] o_battery_charger_status
);

    // --------------------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------------------
    logic [`CDSR_SYNC_W-1:0] sync1_reg;
    logic [`CDSR_SYNC_W-1:0] sync2_reg;
    logic [`CDSR_SYNC_W-1:0] pins;

    assign pins = {i_battery_above_ov_threshold, i_battery_above_2v1, i_temp_above_60c, i_temp_above_45c,
                   i_temp_above_15c, i_temp_above_0c, i_input_above_battery, i_input_above_ovp,
                   i_input_limited, i_input_valid, i_safeout_power_good, i_standby_supply_valid,
                   i_sda, i_scl};

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_reg <= `CDSR_SYNC_RST;
            sync2_reg <= `CDSR_SYNC_RST;
        end
        else
        begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end

    wire scl_s = sync2_reg[`CDSR_S_SCL];
    wire sda_s = sync2_reg[`CDSR_S_SDA];
    wire standby_s = sync2_reg[`CDSR_S_STANDBY];
    wire pgood_s = sync2_reg[`CDSR_S_PGOOD];
    wire in_valid_s = sync2_reg[`CDSR_S_IN_VALID];
    wire t0_s = sync2_reg[`CDSR_S_T0];
    wire t15_s = sync2_reg[`CDSR_S_T15];
    wire t45_s = sync2_reg[`CDSR_S_T45];
    wire t60_s = sync2_reg[`CDSR_S_T60];
    wire bat_alive_s = sync2_reg[`CDSR_S_BAT_2V1];
    wire bat_ov_s = sync2_reg[`CDSR_S_BAT_OV];

    // --------------------------------------------------------------------------
    // reset events and status decode
    // --------------------------------------------------------------------------
    logic pgood_d_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    logic [7:0] input_thermal_reg;
    logic [7:0] input_thermal_next;
    logic [7:0] battery_charger_reg;
    logic [7:0] battery_charger_next;
    cdsr_thm_t thermistor_zone;
    cdsr_bat_t battery_condition;
    cdsr_chg_t charger_state;
    // held in reset for as long as standby is lost, plus one cycle per power-good rising edge
    wire status_clear = !standby_s || (pgood_s && !pgood_d_reg); // see RULE_19
    wire input_voltage_invalid = !in_valid_s; // see RULE_01
    wire input_current_limited = sync2_reg[`CDSR_S_IN_LIMITED]; // see RULE_02
    wire input_overvoltage = sync2_reg[`CDSR_S_IN_OVP]; // see RULE_03
    wire input_above_battery = sync2_reg[`CDSR_S_IN_ABOVE_BAT]; // see RULE_04
    wire zone_suspend = !t0_s || t60_s;
    wire charging_phase = i_phase_prequal || i_phase_fast_cc || i_phase_fast_cv || i_phase_topoff;
    // comparators nest, so the lowest failing threshold picks the zone
    assign thermistor_zone = !t0_s ? CDSR_THM_COLD : // see RULE_06
                             !t15_s ? CDSR_THM_COOL : // see RULE_05
                             !t45_s ? CDSR_THM_NORMAL : // see RULE_05
                             !t60_s ? CDSR_THM_WARM : // see RULE_05
                             CDSR_THM_HOT; // see RULE_06
    // overvoltage first, but gated by a valid input
    assign battery_condition = (in_valid_s && bat_ov_s) ? CDSR_BAT_OVER : // see RULE_10, RULE_11
                               i_timer_fault ? CDSR_BAT_TIMER : // see RULE_08
                               !bat_alive_s ? CDSR_BAT_DEAD : // see RULE_07
                               CDSR_BAT_OK; // see RULE_09
    // charger off outranks every phase; dead battery outranks faults
    assign charger_state = (!in_valid_s || !i_charger_enable) ? CDSR_CHG_OFF : // see RULE_16
                           !bat_alive_s ? CDSR_CHG_DEAD : // see RULE_07, RULE_12
                           i_timer_fault ? CDSR_CHG_TIMER_FAULT : // see RULE_08
                           zone_suspend ? CDSR_CHG_TEMP_SUSPEND : // see RULE_15
                           i_phase_done ? CDSR_CHG_DONE : // see RULE_14
                           (i_thermal_loop_active && charging_phase) ? CDSR_CHG_THERMAL_LOOP : // see RULE_17
                           i_phase_topoff ? CDSR_CHG_TOPOFF : // see RULE_14
                           i_phase_fast_cv ? CDSR_CHG_FAST_CV : // see RULE_13
                           i_phase_fast_cc ? CDSR_CHG_FAST_CC : // see RULE_13
                           CDSR_CHG_PREQUAL; // see RULE_12
    assign input_thermal_next = status_clear ? `CDSR_RST_INPUT_THERMAL :
                                {input_voltage_invalid, input_current_limited, input_overvoltage,
                                 input_above_battery, 1'b0, thermistor_zone}; // see RULE_20
    assign battery_charger_next = status_clear ? `CDSR_RST_BATTERY_CHARGER :
                                  {2'h0, battery_condition, charger_state}; // see RULE_21
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pgood_d_reg <= 1'b0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            input_thermal_reg <= `CDSR_RST_INPUT_THERMAL;
            battery_charger_reg <= `CDSR_RST_BATTERY_CHARGER;
        end
        else
        begin
            pgood_d_reg <= pgood_s;
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            input_thermal_reg <= input_thermal_next;
            battery_charger_reg <= battery_charger_next;
        end
    end

    assign o_input_thermal_status = input_thermal_reg;
    assign o_battery_charger_status = battery_charger_reg;
    // --------------------------------------------------------------------------
    // two-wire target
    // --------------------------------------------------------------------------
    cdsr_state_t state_reg;
    logic [3:0] count_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] pointer_reg;
    logic sda_low_reg;
    logic [7:0] read_data;
    wire scl_rise = scl_s && !scl_d_reg;
    wire scl_fall = !scl_s && scl_d_reg;
    wire bus_start = scl_s && scl_d_reg && !sda_s && sda_d_reg;
    wire bus_stop = scl_s && scl_d_reg && sda_s && !sda_d_reg;
    wire byte_done = scl_fall && (count_reg == 4'h8);
    wire addr_match = (shift_reg[7:1] == `CDSR_TARGET_ADDR); // see RULE_18
    wire receiving = (state_reg == CDSR_ST_ADDR) || (state_reg == CDSR_ST_PTR) || (state_reg == CDSR_ST_WDATA);
    // unmapped offsets read zero; nothing here is writable
    assign read_data = (pointer_reg == `CDSR_OFS_INPUT_THERMAL) ? input_thermal_reg : // see RULE_18
                       (pointer_reg == `CDSR_OFS_BATTERY_CHARGER) ? battery_charger_reg : // see RULE_18
                       `CDSR_UNMAPPED_DATA;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= CDSR_ST_IDLE;
            count_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            pointer_reg <= 8'h00;
            sda_low_reg <= 1'b0;
        end
        else if (bus_start)
        begin
            state_reg <= CDSR_ST_ADDR;
            count_reg <= 4'h0;
            sda_low_reg <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_reg <= CDSR_ST_IDLE;
            sda_low_reg <= 1'b0;
        end
        else if (scl_rise && receiving && (count_reg != 4'h8))
        begin
            shift_reg <= {shift_reg[6:0], sda_s};
            count_reg <= count_reg + 4'h1;
        end
        else if (scl_rise && (state_reg == CDSR_ST_HOST_ACK) && sda_s)
        begin
            // host refused more data; wait for stop or repeated start
            state_reg <= CDSR_ST_IDLE;
        end
        else if (scl_fall)
        begin
            case (state_reg)
                CDSR_ST_ADDR:
                begin
                    if (byte_done)
                    begin
                        state_reg <= addr_match ? CDSR_ST_ADDR_ACK : CDSR_ST_IDLE;
                        sda_low_reg <= addr_match;
                    end
                end
                CDSR_ST_ADDR_ACK:
                begin
                    count_reg <= 4'h0;
                    if (shift_reg[0])
                    begin
                        // the byte is caught whole so a read never tears
                        state_reg <= CDSR_ST_TX;
                        tx_reg <= read_data;
                        sda_low_reg <= !read_data[7];
                        pointer_reg <= pointer_reg + 8'h01;
                    end
                    else
                    begin
                        state_reg <= CDSR_ST_PTR;
                        sda_low_reg <= 1'b0;
                    end
                end
                CDSR_ST_PTR:
                begin
                    if (byte_done)
                    begin
                        pointer_reg <= shift_reg;
                        state_reg <= CDSR_ST_PTR_ACK;
                        sda_low_reg <= 1'b1;
                    end
                end
                CDSR_ST_PTR_ACK:
                begin
                    count_reg <= 4'h0;
                    state_reg <= CDSR_ST_WDATA;
                    sda_low_reg <= 1'b0;
                end
                CDSR_ST_WDATA:
                begin
                    if (byte_done)
                    begin
                        // data is acknowledged and dropped; read-only bank
                        pointer_reg <= pointer_reg + 8'h01; // see RULE_18
                        state_reg <= CDSR_ST_PTR_ACK;
                        sda_low_reg <= 1'b1;
                    end
                end
                CDSR_ST_TX:
                begin
                    if (count_reg == 4'h7)
                    begin
                        state_reg <= CDSR_ST_HOST_ACK;
                        sda_low_reg <= 1'b0;
                    end
                    else
                    begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        sda_low_reg <= !tx_reg[6];
                        count_reg <= count_reg + 4'h1;
                    end
                end
                CDSR_ST_HOST_ACK:
                begin
                    count_reg <= 4'h0;
                    state_reg <= CDSR_ST_TX;
                    tx_reg <= read_data;
                    sda_low_reg <= !read_data[7];
                    pointer_reg <= pointer_reg + 8'h01;
                end
                default:
                begin
                    state_reg <= CDSR_ST_IDLE;
                    sda_low_reg <= 1'b0;
                end
            endcase
        end
    end

    // open drain: only ever pull low
    assign o_sda = 1'b0;
    assign o_sda_oe_n = !sda_low_reg;

    // --------------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------------
    input_invalid_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_01
        !status_clear |=> input_thermal_reg[`CDSR_BIT_INPUT_VOLTAGE_INVALID] == !$past(in_valid_s))
        else $error("input invalid bit does not follow input comparator");
    input_flags_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_02, RULE_03, RULE_04
        !status_clear |=> input_thermal_reg[6:4] == $past({sync2_reg[`CDSR_S_IN_LIMITED],
        sync2_reg[`CDSR_S_IN_OVP], sync2_reg[`CDSR_S_IN_ABOVE_BAT]}))
        else $error("input limit, overvoltage or above battery bit wrong");
    zone_cold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_06
        (!status_clear && !t0_s) |=> input_thermal_reg[2:0] == 3'h1)
        else $error("cold zone not reported");
    zone_warm_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_05
        (!status_clear && t0_s && t15_s && t45_s && !t60_s) |=> input_thermal_reg[2:0] == 3'h4)
        else $error("warm zone not reported");
    dead_battery_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_07
        (!status_clear && in_valid_s && i_charger_enable && !bat_alive_s && !bat_ov_s && !i_timer_fault)
        |=> battery_charger_reg[5:0] == 6'h00)
        else $error("dead battery codes wrong");
    timer_fault_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_08
        (!status_clear && in_valid_s && i_charger_enable && bat_alive_s && !bat_ov_s && i_timer_fault)
        |=> battery_charger_reg[5:0] == 6'h16)
        else $error("timer fault codes wrong");
    bat_over_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_10, RULE_11
        (battery_charger_reg[5:4] == 2'h3) |-> $past(in_valid_s) && $past(bat_ov_s))
        else $error("battery overvoltage reported without cause");
    charger_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_16
        (!status_clear && (!in_valid_s || !i_charger_enable)) |=> battery_charger_reg[3:0] == 4'h8)
        else $error("charger off not reported");
    thermal_loop_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_17
        (battery_charger_reg[3:0] == 4'h9) |-> $past(i_thermal_loop_active) && $past(charging_phase))
        else $error("thermal loop code without cause");
    clear_event_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_19
        $rose(pgood_s) |=> input_thermal_reg == 8'h13 && battery_charger_reg == 8'h28)
        else $error("status not reset on power-good edge");
    zero_bits_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_20, RULE_21
        !input_thermal_reg[3] && battery_charger_reg[7:6] == 2'h0)
        else $error("reserved bits not zero");
    idle_release_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_18
        (state_reg == CDSR_ST_IDLE) |-> !sda_low_reg)
        else $error("data wire held low while idle");
    addr_ack_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_18
        (state_reg == CDSR_ST_ADDR && byte_done && !bus_start && !bus_stop)
        |=> sda_low_reg == $past(shift_reg[7:1] == `CDSR_TARGET_ADDR))
        else $error("address acknowledge wrong");
endmodule : cdsr_status_regs
`default_nettype wire

// >>> dv/cdsr_host_model.sv
/*
 * Two-wire host model that reads and writes the status bank.
 * Assumes a pull-up on the data wire, resolved by the bench.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cdsr_consts.svh"

module cdsr_host_model
(
    input wire logic i_clock,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe_n
);
    // --------------------------------------------------------------------------
    // bus timing: eight cycles each half bit, above the six the target needs
    // --------------------------------------------------------------------------
    initial
    begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end

    task automatic wait_n(input int n);
        repeat (n) @(posedge i_clock);
    endtask : wait_n

    task automatic bit_io(input logic b, output logic r);
        o_scl <= 1'b0;
        wait_n(4);
        o_sda_oe_n <= b;
        wait_n(4);
        o_scl <= 1'b1;
        wait_n(8);
        r = i_sda;
    endtask : bit_io

    // start is (1,0), stop is (0,1): data moves while the clock is high
    task automatic frame(input logic first, input logic last);
        logic r;
        bit_io(first, r);
        o_sda_oe_n <= last;
        wait_n(8);
    endtask : frame

    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : xfer

    task automatic rd(input logic [7:0] p, output logic [7:0] q, output logic ok);
        logic [7:0] j;
        logic a1, a2, a3, a4;
        frame(1'b1, 1'b0);
        xfer({`CDSR_TARGET_ADDR, 1'b0}, j, a1);
        xfer(p, j, a2);
        frame(1'b1, 1'b0);
        xfer({`CDSR_TARGET_ADDR, 1'b1}, j, a3);
        xfer(8'hFF, q, a4);
        frame(1'b0, 1'b1);
        ok = a1 & a2 & a3;
    endtask : rd

    task automatic wr(input logic [7:0] p, input logic [7:0] v, output logic ok);
        logic [7:0] j;
        logic a1, a2, a3;
        frame(1'b1, 1'b0);
        xfer({`CDSR_TARGET_ADDR, 1'b0}, j, a1);
        xfer(p, j, a2);
        xfer(v, j, a3);
        frame(1'b0, 1'b1);
        ok = a1 & a2 & a3;
    endtask : wr
endmodule : cdsr_host_model
`default_nettype wire

// >>> dv/cdsr_status_regs_tb_top.sv
/*
 * Self-checking bench for the status bank: sensor table, serial reads, resets.
 * Assumes the host model and a pull-up on the data wire.
 */
`timescale 1ns/1ns
`default_nettype none

module cdsr_status_regs_tb_top;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic standby = 1'b0;
    logic pgood = 1'b0;
    logic [17:0] stim = 18'h00000;
    logic [7:0] q;
    logic ok;
    logic seen;
    wire logic scl, host_oe_n, dut_sda, dut_oe_n;
    wire logic [7:0] r1, r2;
    wire logic sda_wire = host_oe_n & dut_oe_n;
    int mismatches = 0;
    int compares = 0;
    // {stim, reg1, reg2}; stim bit order follows the port list below
    logic [33:0] vec [15] = '{
        {18'h02539, 8'h13, 8'h22}, {18'h02509, 8'h11, 8'h27}, {18'h02519, 8'h12, 8'h22},
        {18'h02579, 8'h14, 8'h22}, {18'h025F9, 8'h15, 8'h27}, {18'h02736, 8'hE3, 8'h28},
        {18'h02739, 8'h13, 8'h32}, {18'h02439, 8'h13, 8'h00}, {18'h02D39, 8'h13, 8'h16},
        {18'h01539, 8'h13, 8'h21}, {18'h04539, 8'h13, 8'h23}, {18'h08539, 8'h13, 8'h24},
        {18'h10539, 8'h13, 8'h25}, {18'h22539, 8'h13, 8'h29}, {18'h02139, 8'h13, 8'h28}};

    always #4 i_clock = ~i_clock;

    cdsr_status_regs uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_wire),
        .o_sda(dut_sda), .o_sda_oe_n(dut_oe_n), .i_standby_supply_valid(standby),
        .i_safeout_power_good(pgood), .i_input_valid(stim[0]), .i_input_limited(stim[1]),
        .i_input_above_ovp(stim[2]), .i_input_above_battery(stim[3]), .i_temp_above_0c(stim[4]),
        .i_temp_above_15c(stim[5]), .i_temp_above_45c(stim[6]), .i_temp_above_60c(stim[7]),
        .i_battery_above_2v1(stim[8]), .i_battery_above_ov_threshold(stim[9]),
        .i_charger_enable(stim[10]), .i_timer_fault(stim[11]), .i_phase_prequal(stim[12]),
        .i_phase_fast_cc(stim[13]), .i_phase_fast_cv(stim[14]), .i_phase_topoff(stim[15]),
        .i_phase_done(stim[16]), .i_thermal_loop_active(stim[17]),
        .o_input_thermal_status(r1), .o_battery_charger_status(r2));

    cdsr_host_model host (.i_clock(i_clock), .i_sda(sda_wire), .o_scl(scl), .o_sda_oe_n(host_oe_n));

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (20) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        chk("reg1 reset", 8'h13, r1);
        chk("reg2 reset", 8'h28, r2);
        standby <= 1'b1;
        for (int k = 0; k < 15; k++)
        begin
            stim <= vec[k][33:16];
            repeat (5) @(posedge i_clock);
            chk("input_thermal_status", vec[k][15:8], r1);
            chk("battery_charger_status", vec[k][7:0], r2);
            chk("charger_state", vec[k][3:0], r2[3:0]);
        end
        stim <= 18'h02539;
        host.rd(8'h03, q, ok);
        chk("read 0x03", 8'h13, q);
        chk("ack 0x03", 8'h01, {7'h00, ok});
        host.wr(8'h04, 8'hFF, ok);
        chk("ack write", 8'h01, {7'h00, ok});
        host.rd(8'h04, q, ok);
        chk("read 0x04", 8'h22, q);
        host.rd(8'h05, q, ok);
        chk("read 0x05", 8'h00, q);
        pgood <= 1'b1;
        seen = 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            @(posedge i_clock);
            if (r2 === 8'h28)
                seen = 1'b1;
        end
        chk("power good reset", 8'h01, {7'h00, seen});
        chk("after power good", 8'h22, r2);
        standby <= 1'b0;
        repeat (5) @(posedge i_clock);
        chk("standby loss reg1", 8'h13, r1);
        chk("standby loss reg2", 8'h28, r2);
        chk("sda drive level", 8'h00, {7'h00, dut_sda});
        end_sim();
    end
endmodule : cdsr_status_regs_tb_top
`default_nettype wire
